// ===== msm_spi_master.sv
// Purpose: Four-wire serial master sharing one bus among four slaves
// Assumes: Register port strobes are single-cycle and come from the clock_i domain
// Notes: Serial clock idles high; slave data is captured on the rising serial edge
// What this block does
// R1 - Every unit on the link is one eight-bit frame; blocks are back-to-back frames.
// R2 - Each frame goes most significant bit first, least significant last.
// R3 - Serial clock rests high whenever no frame is shifting.
// R4 - Master data out rests low whenever no frame is shifting.
// R5 - Master drives clock and data out, samples data in, both ways at once.
// R6 - Transmit-empty and receive-full events exist and are enabled by initialisation.
// R7 - Base divide one; rate setting zero is the fast rate, one the half rate.
// R8 - Host finishes initialisation before asking for any transfer.
// R9 - Initialisation takes channel zero or one; all slaves sit on channel zero.
// R10 - One select output per slave; at most one asserted, deasserted on separate request.
// R11 - Host asserts the slave select before a block read and holds it throughout.
// R12 - Block read takes a 16-bit count and moves exactly that many frames.
// R13 - The byte index advances by one after every received byte.
// R14 - Block reports when its transmit data register is empty, for polling.
// R15 - An ownership lock is offered; requesters take it before selecting a slave.
// R16 - Lock succeeds only when free; release only for the owner; else failure.
// R17 - Block write sends the given count of bytes, source index advancing per byte.
// R18 - During a block read a constant filler byte is shifted out each frame.
// R19 - Transfer reports success when all frames end; failure before init or zero count.
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module msm_spi_master
    import msm_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Register port
    input wire msm_pkg::msm_bus_req_t bus_i,
    output logic [msm_pkg::DATA_W-1:0] rdata_o,
    // Serial link
    output logic serial_clock_out_pin_o,
    output logic master_data_out_pin_o,
    input wire logic master_data_in_pin_i,
    output logic [msm_pkg::NUM_SLAVES-1:0] peripheral_select_line_n_o,
    // Events
    output logic transmit_empty_event_o,
    output logic receive_full_event_o
);
    import msm_pkg::*;

    msm_state_t state_r;
    logic init_r, chan_r, rate_r, evt_en_r, dir_read_r;
    logic ok_r, fail_r, tx_evt_r, rx_evt_r;
    logic lock_held_r, lock_ok_r, unlock_ok_r;
    logic [PID_W-1:0] owner_r;
    logic [COUNT_W-1:0] count_r, index_r;
    logic [FRAME_BITS-1:0] shift_r, rx_shift_r;
    logic [2:0] bit_cnt_r;
    logic [HALF_W-1:0] half_cnt_r;
    logic sclk_r, mosi_r, miso_m_r, miso_s_r;
    logic [NUM_SLAVES-1:0] sel_r;
    logic [DATA_W-1:0] rdata_r;
    logic tx_pulse_r, rx_pulse_r;

    logic wr_init, wr_sel, wr_desel, wr_lock, wr_unlock, wr_xfer, wr_tx, rd_rx, rd_status;
    logic start_ok, load_go, half_end, bit_last, frame_done, xfer_last;
    logic [HALF_W-1:0] half_len;
    logic [DEV_W-1:0] dev_w;
    logic [PID_W-1:0] pid_w;
    logic [COUNT_W-1:0] count_w;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [FRAME_BITS-1:0] fifo_in_data, fifo_out_data;

    assign wr_init = bus_i.wr && (bus_i.addr == REG_INIT);
    assign wr_sel = bus_i.wr && (bus_i.addr == REG_SELECT);
    assign wr_desel = bus_i.wr && (bus_i.addr == REG_DESELECT);
    assign wr_lock = bus_i.wr && (bus_i.addr == REG_LOCK);
    assign wr_unlock = bus_i.wr && (bus_i.addr == REG_UNLOCK);
    assign wr_xfer = bus_i.wr && (bus_i.addr == REG_XFER);
    assign wr_tx = bus_i.wr && (bus_i.addr == REG_TXDATA);
    assign rd_rx = bus_i.rd && (bus_i.addr == REG_RXDATA);
    assign rd_status = bus_i.rd && (bus_i.addr == REG_STATUS);
    assign dev_w = bus_i.wdata[DEV_W-1:0];
    assign pid_w = bus_i.wdata[PID_W-1:0];
    assign count_w = bus_i.wdata[COUNT_W-1:0];

    // A transfer is refused unless initialised, idle and non-empty
    assign start_ok = wr_xfer && init_r && (state_r == ST_IDLE) && (count_w != '0); // R19 R8
    assign half_len = rate_r ? HALF_RATE1 : HALF_RATE0; // R7
    assign half_end = (half_cnt_r == half_len - 1'b1);
    assign bit_last = (bit_cnt_r == 3'(FRAME_BITS - 1)); // R1
    assign frame_done = (state_r == ST_HIGH) && half_end && bit_last;
    assign xfer_last = ((index_r + 1'b1) == count_r); // R12 R17
    // Reads wait for room so no received byte is ever dropped
    assign load_go = (state_r == ST_LOAD) && (dir_read_r ? fifo_in_ready : fifo_out_valid);

    // One FIFO carries received bytes in read mode and outgoing bytes in write mode
    assign fifo_in_valid = dir_read_r ? frame_done : wr_tx;
    assign fifo_in_data = dir_read_r ? rx_shift_r : bus_i.wdata[FRAME_BITS-1:0];
    assign fifo_out_ready = dir_read_r ? rd_rx : load_go;

    msm_fifo #(
        .WIDTH(FRAME_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            miso_m_r <= 1'b0;
            miso_s_r <= 1'b0;
        end else begin
            miso_m_r <= master_data_in_pin_i;
            miso_s_r <= miso_m_r;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: if (start_ok) state_r <= ST_LOAD;
                ST_LOAD: if (load_go) state_r <= ST_LOW;
                ST_LOW: if (half_end) state_r <= ST_HIGH;
                ST_HIGH: begin
                    if (half_end) begin
                        if (!bit_last) begin
                            state_r <= ST_LOW;
                        end else begin
                            state_r <= xfer_last ? ST_IDLE : ST_LOAD; // R1 R12
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            half_cnt_r <= '0;
            bit_cnt_r <= '0;
        end else begin
            if (state_r == ST_LOAD || half_end) begin
                half_cnt_r <= '0;
            end else begin
                half_cnt_r <= half_cnt_r + 1'b1;
            end
            if (state_r == ST_LOAD) begin
                bit_cnt_r <= '0;
            end else if (state_r == ST_HIGH && half_end) begin
                bit_cnt_r <= bit_cnt_r + 1'b1;
            end
        end
    end

    // Data leaves on the falling serial edge and is taken on the rising one
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sclk_r <= 1'b1;
            mosi_r <= 1'b0;
            shift_r <= '0;
            rx_shift_r <= '0;
        end else begin
            if (load_go) begin
                shift_r <= dir_read_r ? FILLER_BYTE : fifo_out_data; // R18 R17
                mosi_r <= dir_read_r ? FILLER_BYTE[FRAME_BITS-1] : fifo_out_data[FRAME_BITS-1]; // R2
                sclk_r <= 1'b0;
            end else if (state_r == ST_LOW && half_end) begin
                sclk_r <= 1'b1;
                rx_shift_r <= {rx_shift_r[FRAME_BITS-2:0], miso_s_r}; // R5 R2
            end else if (state_r == ST_HIGH && half_end) begin
                if (bit_last) begin
                    sclk_r <= 1'b1; // R3
                    mosi_r <= 1'b0; // R4
                end else begin
                    sclk_r <= 1'b0;
                    shift_r <= {shift_r[FRAME_BITS-2:0], 1'b0};
                    mosi_r <= shift_r[FRAME_BITS-2]; // R2
                end
            end
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            init_r <= 1'b0;
            chan_r <= 1'b0;
            rate_r <= 1'b0;
            evt_en_r <= 1'b0;
        end else if (wr_init) begin
            init_r <= 1'b1;
            chan_r <= bus_i.wdata[INIT_CHAN_BIT]; // R9
            rate_r <= bus_i.wdata[INIT_RATE_BIT]; // R7
            evt_en_r <= 1'b1; // R6
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_r <= '0;
            index_r <= '0;
            dir_read_r <= 1'b0;
            ok_r <= 1'b0;
            fail_r <= 1'b0;
        end else begin
            if (wr_xfer) begin
                fail_r <= !start_ok; // R19
            end
            // Completion wins over a refused request landing in the same cycle
            if (frame_done && xfer_last) begin
                ok_r <= 1'b1; // R19
            end else if (wr_xfer) begin
                ok_r <= 1'b0;
            end
            if (start_ok) begin
                count_r <= count_w; // R12
                index_r <= '0;
                dir_read_r <= bus_i.wdata[XFER_DIR_BIT];
            end else if (frame_done) begin
                index_r <= index_r + 1'b1; // R13 R17
            end
        end
    end

    // Sticky event flags clear on a status read, but a new event wins
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_evt_r <= 1'b0;
            rx_evt_r <= 1'b0;
            tx_pulse_r <= 1'b0;
            rx_pulse_r <= 1'b0;
        end else begin
            tx_pulse_r <= evt_en_r && load_go; // R6
            rx_pulse_r <= evt_en_r && frame_done; // R6
            if (evt_en_r && load_go) begin
                tx_evt_r <= 1'b1;
            end else if (rd_status) begin
                tx_evt_r <= 1'b0;
            end
            if (evt_en_r && frame_done) begin
                rx_evt_r <= 1'b1;
            end else if (rd_status) begin
                rx_evt_r <= 1'b0;
            end
        end
    end

    // The lock is advisory; selects and transfers do not check ownership
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lock_held_r <= 1'b0;
            owner_r <= '0;
            lock_ok_r <= 1'b0;
            unlock_ok_r <= 1'b0;
        end else if (wr_lock) begin
            lock_ok_r <= !lock_held_r; // R16 R15
            if (!lock_held_r) begin
                lock_held_r <= 1'b1;
                owner_r <= pid_w;
            end
        end else if (wr_unlock) begin
            unlock_ok_r <= lock_held_r && (pid_w == owner_r); // R16
            if (lock_held_r && (pid_w == owner_r)) begin
                lock_held_r <= 1'b0;
            end
        end
    end

    generate
        for (genvar s = 0; s < NUM_SLAVES; s++) begin : g_sel
            always_ff @(posedge clock_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    sel_r[s] <= 1'b0;
                end else if (wr_sel) begin
                    sel_r[s] <= (dev_w == DEV_W'(s + 1)); // R10
                end else if (wr_desel && dev_w == DEV_W'(s + 1)) begin
                    sel_r[s] <= 1'b0; // R10
                end
            end
        end
    endgenerate

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_r <= '0;
        end else if (bus_i.rd) begin
            rdata_r <= '0;
            unique case (bus_i.addr)
                REG_RXDATA: if (dir_read_r) rdata_r[FRAME_BITS-1:0] <= fifo_out_data;
                REG_LOCK: rdata_r[PID_W-1:0] <= owner_r;
                REG_INDEX: rdata_r <= {count_r, index_r};
                REG_STATUS: begin
                    rdata_r[ST_INIT_BIT] <= init_r;
                    rdata_r[ST_BUSY_BIT] <= (state_r != ST_IDLE);
                    rdata_r[ST_OK_BIT] <= ok_r;
                    rdata_r[ST_FAIL_BIT] <= fail_r;
                    rdata_r[ST_TXEV_BIT] <= tx_evt_r;
                    rdata_r[ST_RXEV_BIT] <= rx_evt_r;
                    rdata_r[ST_TXEMPTY_BIT] <= !fifo_out_valid && (state_r == ST_IDLE || state_r == ST_LOAD); // R14
                    rdata_r[ST_FULL_BIT] <= !fifo_in_ready;
                    rdata_r[ST_EMPTY_BIT] <= !fifo_out_valid;
                    rdata_r[ST_HELD_BIT] <= lock_held_r;
                    rdata_r[ST_LOCKOK_BIT] <= lock_ok_r;
                    rdata_r[ST_UNLOCKOK_BIT] <= unlock_ok_r;
                    rdata_r[ST_CHAN_BIT] <= chan_r;
                    rdata_r[ST_RATE_BIT] <= rate_r;
                    rdata_r[ST_DIR_BIT] <= dir_read_r;
                end
                default: rdata_r <= '0;
            endcase
        end else begin
            rdata_r <= '0;
        end
    end

    assign rdata_o = rdata_r;
    assign serial_clock_out_pin_o = sclk_r;
    assign master_data_out_pin_o = mosi_r;
    assign peripheral_select_line_n_o = ~sel_r;
    assign transmit_empty_event_o = tx_pulse_r;
    assign receive_full_event_o = rx_pulse_r;

    // Helper: rising serial edges seen in the current frame
    logic sclk_d_r;
    logic [3:0] rises_r;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sclk_d_r <= 1'b1;
            rises_r <= '0;
        end else begin
            sclk_d_r <= sclk_r;
            if (state_r == ST_LOAD) begin
                rises_r <= '0;
            end else if (sclk_r && !sclk_d_r) begin
                rises_r <= rises_r + 1'b1;
            end
        end
    end

    sclk_idle_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R3
        (state_r == ST_IDLE || state_r == ST_LOAD) |-> sclk_r)
        else $error("serial clock not high while idle");
    mosi_idle_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R4
        (state_r == ST_IDLE) |-> !mosi_r)
        else $error("data out not low while idle");
    frame_bits_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R1
        frame_done |-> (5'(rises_r) + 5'(sclk_r && !sclk_d_r)) == 5'(FRAME_BITS))
        else $error("frame did not carry eight clocks");
    msb_first_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R2
        load_go && !dir_read_r |=> mosi_r == $past(fifo_out_data[FRAME_BITS-1]))
        else $error("first bit out is not the top bit");
    sel_onehot_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R10
        $onehot0(~peripheral_select_line_n_o))
        else $error("more than one slave selected");
    lock_busy_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R16
        wr_lock && lock_held_r |=> !lock_ok_r && lock_held_r && $stable(owner_r))
        else $error("lock taken while owned");
    unlock_foreign_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R16
        wr_unlock && (pid_w != owner_r) |=> !unlock_ok_r && lock_held_r == $past(lock_held_r))
        else $error("lock released by non-owner");
    count_done_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R12
        frame_done && xfer_last |=> ok_r && (index_r == count_r) && (state_r == ST_IDLE))
        else $error("transfer ended with wrong frame count");
    index_step_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R13
        frame_done |=> index_r == $past(index_r) + 1'b1)
        else $error("index did not advance by one");
    zero_fail_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R19
        wr_xfer && (state_r == ST_IDLE) && (count_w == '0 || !init_r) |=> fail_r && !ok_r && (state_r == ST_IDLE))
        else $error("bad transfer request not refused");
    filler_out_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R18
        load_go && dir_read_r |=> shift_r == FILLER_BYTE && mosi_r == FILLER_BYTE[FRAME_BITS-1])
        else $error("read frame not sending filler");
    rx_event_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R6
        frame_done && evt_en_r |=> rx_evt_r && receive_full_event_o ##1 !receive_full_event_o || frame_done)
        else $error("receive event missing");
    half_rate_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R7
        $rose(sclk_r) && rate_r |=> sclk_r ##1 (!sclk_r || state_r == ST_IDLE || state_r == ST_LOAD))
        else $error("slow rate high phase too short");
endmodule // msm_spi_master

// ===== msm_pkg.sv
// Purpose: Shared constants, types and register map of the multi-slave serial master
// Assumes: 50 MHz system clock, 32-bit register port with byte addresses
// Notes: All offsets are word aligned; unused bits read as zero
package msm_pkg;
    // Register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_INIT = 8'h00;
    localparam logic [ADDR_W-1:0] REG_SELECT = 8'h04;
    localparam logic [ADDR_W-1:0] REG_DESELECT = 8'h08;
    localparam logic [ADDR_W-1:0] REG_LOCK = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_UNLOCK = 8'h10;
    localparam logic [ADDR_W-1:0] REG_XFER = 8'h14;
    localparam logic [ADDR_W-1:0] REG_TXDATA = 8'h18;
    localparam logic [ADDR_W-1:0] REG_RXDATA = 8'h1C;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h20;
    localparam logic [ADDR_W-1:0] REG_INDEX = 8'h24;

    // Field positions
    localparam int INIT_CHAN_BIT = 0;
    localparam int INIT_RATE_BIT = 1;
    localparam int XFER_DIR_BIT = 16;
    localparam int DEV_W = 3;
    localparam int COUNT_W = 16;
    localparam int PID_W = 16;
    localparam int ST_INIT_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_OK_BIT = 2;
    localparam int ST_FAIL_BIT = 3;
    localparam int ST_TXEV_BIT = 4;
    localparam int ST_RXEV_BIT = 5;
    localparam int ST_TXEMPTY_BIT = 6;
    localparam int ST_FULL_BIT = 7;
    localparam int ST_EMPTY_BIT = 8;
    localparam int ST_HELD_BIT = 9;
    localparam int ST_LOCKOK_BIT = 10;
    localparam int ST_UNLOCKOK_BIT = 11;
    localparam int ST_CHAN_BIT = 12;
    localparam int ST_RATE_BIT = 13;
    localparam int ST_DIR_BIT = 14;

    // Link format
    localparam int NUM_SLAVES = 4;
    localparam int FRAME_BITS = 8;
    localparam logic [FRAME_BITS-1:0] FILLER_BYTE = 8'hFF;
    localparam logic [DEV_W-1:0] DEV_NONE = 3'h0;

    // Bit rate: half period in system clocks, rounded down, never below one
    localparam int CLK_MHZ = 50;
    localparam int BASE_DIV = 1;
    localparam int RATE0_MBPS = 24;
    localparam int RATE1_MBPS = 12;
    localparam int HALF0_RAW = CLK_MHZ / (2 * RATE0_MBPS * BASE_DIV);
    localparam int HALF1_RAW = CLK_MHZ / (2 * RATE1_MBPS * BASE_DIV);
    localparam int HALF_W = 8;
    localparam logic [HALF_W-1:0] HALF_RATE0 = HALF_W'((HALF0_RAW < 1) ? 1 : HALF0_RAW);
    localparam logic [HALF_W-1:0] HALF_RATE1 = HALF_W'((HALF1_RAW < 1) ? 1 : HALF1_RAW);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_LOW = 2'b10,
        ST_HIGH = 2'b11
    } msm_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } msm_bus_req_t;
endpackage

// ===== msm_fifo.sv
// Purpose: Flop-based FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: Read data is the head entry, valid while out_valid_o is high
`timescale 1ns/1ps
module msm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [PTR_W:0] count_r;
    logic push;
    logic pop;

    assign in_ready_o = (count_r != (PTR_W+1)'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_r[rd_ptr_r];

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule // msm_fifo

// ===== msm_slave_model.sv
// Purpose: Behavioural slave on the far side of the serial link
// Assumes: Mode with clock idling high, data captured on the rising serial edge
// Notes: Reply bytes count up by 0x11 from 0xC3, one per frame
`timescale 1ns/1ps
module msm_slave_model (
    // Link from the master
    input wire logic reset_n_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic [3:0] sel_n_i,
    // Link to the master
    output logic miso_o
);
    logic [7:0] tx_r, byte_r, rx_r;
    logic [2:0] bit_r;
    logic [7:0] got [0:15];
    int n;
    always @(posedge sclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_r <= 8'hC3;
            byte_r <= 8'hC3;
            bit_r <= 3'h0;
            n <= 0;
        end else if (!(&sel_n_i)) begin
            rx_r <= {rx_r[6:0], mosi_i};
            bit_r <= bit_r + 3'h1;
            if (bit_r == 3'h7) begin
                got[n] <= {rx_r[6:0], mosi_i};
                n <= n + 1;
                tx_r <= byte_r + 8'h11;
                byte_r <= byte_r + 8'h11;
            end else begin
                tx_r <= {tx_r[6:0], 1'b0};
            end
        end
    end
    // Deselected line shows the inverse so a stale bit never looks right
    assign miso_o = (&sel_n_i) ? ~tx_r[7] : tx_r[7];
endmodule // msm_slave_model

// ===== multi_slave_spi_master_tb.sv
// Purpose: Register-level tests of the serial master against the slave model
// Assumes: Tasks start just after a rising edge
// Notes: Slow rate used so the synchronised input has margin
`timescale 1ns/1ps
module multi_slave_spi_master_tb;
    import msm_pkg::*;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    msm_bus_req_t bus = '0;
    logic [DATA_W-1:0] rdata, s;
    logic sclk, mosi, miso, txe, rxf;
    logic [3:0] sel_n;
    int err_count = 0, check_count = 0, cyc = 0, ntx = 0, nrx = 0, t_tx = 0, t_rx = 0;
    logic [7:0] op_a [4] = '{REG_LOCK, REG_LOCK, REG_UNLOCK, REG_UNLOCK};
    logic [15:0] op_p [4] = '{16'h5, 16'h7, 16'h7, 16'h5};
    logic [2:0] op_e [4] = '{3'h6, 3'h4, 3'h4, 3'h1};
    always #10 clock_i = ~clock_i;
    msm_spi_master #(.FIFO_DEPTH(16)) u_msm_spi_master (.clock_i(clock_i), .reset_n_i(reset_n_i), .bus_i(bus),
        .rdata_o(rdata), .serial_clock_out_pin_o(sclk), .master_data_out_pin_o(mosi), .master_data_in_pin_i(miso),
        .peripheral_select_line_n_o(sel_n), .transmit_empty_event_o(txe), .receive_full_event_o(rxf));
    msm_slave_model u_msm_slave_model (.reset_n_i(reset_n_i), .sclk_i(sclk), .mosi_i(mosi), .sel_n_i(sel_n),
        .miso_o(miso));
    task give_verdict();
        if (err_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Hang guard: the whole sequence needs well under the twenty thousand cycles allowed
    always @(posedge clock_i) begin
        cyc++;
        if (txe === 1'b1) begin
            ntx++;
            t_tx = cyc;
        end
        if (rxf === 1'b1) begin
            nrx++;
            t_rx = cyc;
        end
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        #1;
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clock_i);
        bus.wr <= 1'b0;
        @(posedge clock_i);
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clock_i);
        bus.rd <= 1'b0;
        #1 d = rdata;
        @(posedge clock_i);
    endtask
    task wait_ok();
        for (int k = 0; k < 300; k++) begin
            rd(REG_STATUS, s);
            if (s[ST_OK_BIT] === 1'b1) break;
        end
        chk(s[ST_OK_BIT], 1);
    endtask
    initial begin
        repeat (8) @(posedge clock_i);
        reset_n_i <= 1'b1;
        @(posedge clock_i);
        chk({sclk, mosi, sel_n}, 6'h2F);
        wr(REG_XFER, 32'h1);
        rd(REG_STATUS, s);
        chk(s[ST_FAIL_BIT], 1);
        wr(REG_INIT, 32'h2);
        wr(REG_XFER, 32'h0);
        rd(REG_STATUS, s);
        chk({s[ST_RATE_BIT], s[ST_CHAN_BIT], s[ST_FAIL_BIT], s[ST_INIT_BIT]}, 4'hB);
        wr(REG_SELECT, 32'h2);
        chk(sel_n, 4'hD);
        wr(REG_DESELECT, 32'h1);
        chk(sel_n, 4'hD);
        wr(REG_DESELECT, 32'h2);
        chk(sel_n, 4'hF);
        wr(REG_SELECT, 32'h1);
        chk(sel_n, 4'hE);
        wr(REG_TXDATA, 32'hA5);
        wr(REG_TXDATA, 32'h3C);
        wr(REG_TXDATA, 32'h81);
        wr(REG_XFER, 32'h3);
        wait_ok();
        chk(u_msm_slave_model.got[0], 8'hA5);
        chk(u_msm_slave_model.got[1], 8'h3C);
        chk(u_msm_slave_model.got[2], 8'h81);
        chk(ntx, 3);
        chk(nrx, 3);
        chk(t_rx - t_tx, 2 * FRAME_BITS * HALF_RATE1);
        rd(REG_INDEX, s);
        chk(s, 32'h0003_0003);
        rd(REG_STATUS, s);
        chk(s[ST_TXEMPTY_BIT], 1);
        wr(REG_XFER, 32'h1_0004);
        wait_ok();
        for (int i = 0; i < 4; i++) begin
            chk(u_msm_slave_model.got[3 + i], FILLER_BYTE);
            rd(REG_RXDATA, s);
            chk(s[7:0], 8'(8'hC3 + 8'h11 * (3 + i)));
        end
        rd(REG_INDEX, s);
        chk(s, 32'h0004_0004);
        rd(REG_STATUS, s);
        chk(s[ST_EMPTY_BIT], 1);
        // Fast rate, write only: the engine waits in load until the byte arrives
        wr(REG_INIT, 32'h0);
        wr(REG_XFER, 32'h1);
        wr(REG_TXDATA, 32'h5A);
        wait_ok();
        chk(u_msm_slave_model.got[7], 8'h5A);
        chk(t_rx - t_tx, 2 * FRAME_BITS * HALF_RATE0);
        for (int i = 0; i < 4; i++) begin
            wr(op_a[i], {16'h0, op_p[i]});
            rd(REG_STATUS, s);
            chk({s[ST_HELD_BIT], s[ST_LOCKOK_BIT], s[ST_UNLOCKOK_BIT]}, op_e[i]);
        end
        rd(8'h40, s);
        chk(s, 32'h0);
        give_verdict();
    end
endmodule // multi_slave_spi_master_tb
